// [rtl/adc_seq_pkg.sv]
// Constants, register map and carrier types of the converter sequencer.
// Assumes an 8-bit special function register port in the CPU clock domain.
package adc_seq_pkg;

	// Register offsets on the special function register port
	localparam logic [7:0] ADC_CLOCK_DIVIDER_OFS = 8'hF2;
	localparam logic [7:0] ADC_CONTROL_OFS = 8'hF3;
	localparam logic [7:0] ADC_RESULT_LOW_OFS = 8'hF4;
	localparam logic [7:0] ADC_RESULT_HIGH_OFS = 8'hF5;
	localparam logic [7:0] ADC_PIN_CONFIG_OFS = 8'hF6;

	// Control and clock divider register fields
	localparam int QUIET_CPU_MODE_BIT = 6;
	localparam int ADC_POWER_ENABLE_BIT = 5;
	localparam int CONV_DONE_FLAG_BIT = 4;
	localparam int START_BUSY_BIT = 3;
	localparam int INPUT_SELECT_MSB = 2;
	localparam int INPUT_SELECT_LSB = 0;
	localparam int CLOCK_DIVIDER_MSB = 4;

	// Reset values
	localparam logic [7:0] ADC_REG_RESET = 8'h00;
	localparam logic [9:0] RESULT_RESET = 10'h000;

	// Conversion timing in converter clock cycles
	localparam int SAMPLE_CYCLES = 1;
	localparam int RESULT_BITS = 10;
	localparam int CONV_CYCLES = SAMPLE_CYCLES + RESULT_BITS;
	// Prescaler: zero field divides by 64, otherwise by twice the field
	localparam logic [5:0] DIV_ZERO_RELOAD = 6'h3F;
	localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
	localparam logic [3:0] SAR_MSB_INDEX = 4'h9;

	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_SAMPLE,
		ST_CONVERT,
		ST_DONE
	} conv_state_t;

	// One access on the special function register port
	typedef struct packed
	{
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} sfr_req_t;

	// Controls toward the analog core
	typedef struct packed
	{
		logic power;
		logic sample;
		logic [2:0] mux_sel;
		logic [9:0] dac_code;
	} core_ctrl_t;

	// Whole state of the sequencer
	typedef struct packed
	{
		conv_state_t st;
		logic [4:0] prescale;
		logic quiet;
		logic power;
		logic done;
		logic busy;
		logic [2:0] sel;
		logic [2:0] conv_ch;
		logic [7:0] pin_cfg;
		logic [9:0] result;
		logic [9:0] sar;
		logic [3:0] bit_idx;
		logic [5:0] div_cnt;
		logic sample;
		logic [7:0] rdata;
		logic irq;
		logic halt;
		logic hold;
	} regs_t;

	localparam regs_t REGS_RESET = regs_t'(0);

endpackage : adc_seq_pkg

// [rtl/adc_sequencer_control.sv]
// Sequencer of an eight-input 10-bit successive approximation converter.
// Assumes the CPU special function register port, a comparator from the
// analog core that is synchronous to clk, and an external interrupt
// controller that holds the converter interrupt enable bit.
`timescale 1ns/1ps

module adc_sequencer_control
	import adc_seq_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic adc_irq_enable,
	input wire logic cmp_above,
	output core_ctrl_t core_ctrl,
	output logic [7:0] pin_analog_bits,
	output logic adc_irq,
	output logic cpu_halt,
	output logic other_irq_hold
);

	logic rst_meta_r;
	logic rst_sync_n_r;
	regs_t r;
	regs_t n;

	// Prescaler reload value, used at start and at every converter tick
	function automatic logic [5:0] div_reload(input logic [4:0] prs);
		logic [5:0] d;
		d = DIV_ZERO_RELOAD;
		if (prs != 5'h00)
			d = 6'({prs, 1'b0} - 6'h01);
		return d;
	endfunction : div_reload

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	// Async assert, synchronous release
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_r <= 1'b0;
			rst_sync_n_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_sync_n_r <= rst_meta_r;
		end
	end

	always_comb
	begin
		logic adc_tick;
		logic start;
		logic pwr_new;
		logic [2:0] sel_new;
		adc_tick = r.busy && (r.div_cnt == 6'h00);
		start = 1'b0;
		pwr_new = r.power;
		sel_new = r.sel;
		n = r;

		// Divider only runs during a conversion
		if (r.busy)
		begin
			if (adc_tick)
				n.div_cnt = div_reload(r.prescale);
			else
				n.div_cnt = 6'(r.div_cnt - 6'h01);
		end

		// Software writes; done flag is cleared here and set below
		if (sfr_req.wr)
		begin
			if (hit(sfr_req.addr, ADC_CLOCK_DIVIDER_OFS))
				n.prescale = sfr_req.wdata[CLOCK_DIVIDER_MSB:0];
			else if (hit(sfr_req.addr, ADC_CONTROL_OFS))
			begin
				sel_new = sfr_req.wdata[INPUT_SELECT_MSB:INPUT_SELECT_LSB];
				pwr_new = sfr_req.wdata[ADC_POWER_ENABLE_BIT];
				n.sel = sel_new;
				n.power = pwr_new;
				n.quiet = sfr_req.wdata[QUIET_CPU_MODE_BIT];
				if (!sfr_req.wdata[CONV_DONE_FLAG_BIT])
					n.done = 1'b0;
				// Writing zero to the start bit never aborts
				start = sfr_req.wdata[START_BUSY_BIT] && !r.busy && pwr_new
					&& r.pin_cfg[sel_new];
			end
			else if (hit(sfr_req.addr, ADC_PIN_CONFIG_OFS))
				n.pin_cfg = sfr_req.wdata;
		end

		case (r.st)
			ST_SAMPLE:
			begin
				if (adc_tick)
				begin
					n.sample = 1'b0;
					n.st = ST_CONVERT;
					n.bit_idx = SAR_MSB_INDEX;
					n.sar = SAR_FIRST_TRIAL;
				end
			end
			ST_CONVERT:
			begin
				if (adc_tick)
				begin
					// Keep the trial bit while input is at or above it
					n.sar[r.bit_idx] = cmp_above;
					if (r.bit_idx == 4'h0)
					begin
						n.result = n.sar;
						n.st = ST_DONE;
					end
					else
					begin
						n.bit_idx = 4'(r.bit_idx - 4'h1);
						n.sar[4'(r.bit_idx - 4'h1)] = 1'b1;
					end
				end
			end
			ST_DONE:
			begin
				// Flag rises one cycle after the result registers
				n.done = 1'b1;
				n.busy = 1'b0;
				n.hold = 1'b0;
				n.st = ST_IDLE;
			end
			default:
			begin
				n.st = ST_IDLE;
			end
		endcase

		if (start)
		begin
			n.busy = 1'b1;
			n.st = ST_SAMPLE;
			n.conv_ch = sel_new;
			n.sample = 1'b1;
			n.sar = RESULT_RESET;
			n.div_cnt = div_reload(r.prescale);
			// Precision mode: CPU halts unless the end interrupt is still raised, other interrupts wait
			n.halt = sfr_req.wdata[QUIET_CPU_MODE_BIT];
			n.hold = sfr_req.wdata[QUIET_CPU_MODE_BIT];
		end

		// Standby aborts a running conversion without a result
		if (!n.power && r.busy)
		begin
			n.busy = 1'b0;
			n.st = ST_IDLE;
			n.sample = 1'b0;
			n.hold = 1'b0;
			n.halt = 1'b0;
		end

		n.irq = n.done && adc_irq_enable;
		// The end interrupt wakes the CPU; a standby abort above also clears the halt
		if (r.irq)
			n.halt = 1'b0;

		if (sfr_req.rd)
		begin
			if (hit(sfr_req.addr, ADC_CLOCK_DIVIDER_OFS))
				n.rdata = {3'h0, r.prescale};
			else if (hit(sfr_req.addr, ADC_CONTROL_OFS))
				n.rdata = {1'b0, r.quiet, r.power, r.done, r.busy,
					r.sel};
			else if (hit(sfr_req.addr, ADC_RESULT_LOW_OFS))
				n.rdata = {6'h00, r.result[1:0]};
			else if (hit(sfr_req.addr, ADC_RESULT_HIGH_OFS))
				n.rdata = r.result[9:2];
			else if (hit(sfr_req.addr, ADC_PIN_CONFIG_OFS))
				n.rdata = r.pin_cfg;
			else
				n.rdata = ADC_REG_RESET;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n_r)
	begin
		if (!rst_sync_n_r)
			r <= REGS_RESET;
		else
			r <= n;
	end

	assign sfr_rdata = r.rdata;
	assign core_ctrl.power = r.power;
	assign core_ctrl.sample = r.sample;
	assign core_ctrl.mux_sel = r.conv_ch;
	assign core_ctrl.dac_code = r.sar;
	assign pin_analog_bits = r.pin_cfg;
	assign adc_irq = r.irq;
	assign cpu_halt = r.halt;
	assign other_irq_hold = r.hold;

endmodule : adc_sequencer_control

// [sim/adc_seq_chk_sva.sv]
`timescale 1ns/1ps
// Port checker of the converter sequencer.
// Assumes a bind to the top module, one clock.
module adc_seq_chk
	import adc_seq_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input sfr_req_t sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic adc_irq_enable,
	input wire logic cmp_above,
	input core_ctrl_t core_ctrl,
	input wire logic [7:0] pin_analog_bits,
	input wire logic adc_irq,
	input wire logic cpu_halt,
	input wire logic other_irq_hold
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	sequence ctl_wr;
		sfr_req.wr && sfr_req.addr == ADC_CONTROL_OFS;
	endsequence
	sequence start_seen;
		$rose(core_ctrl.sample);
	endsequence
	chk_start_cause: assert property (start_seen |-> $past(sfr_req.wr)
		&& $past(sfr_req.wdata[5]) && $past(sfr_req.wdata[3]))
		else $error("start cause");
	chk_chan_latch: assert property (start_seen |->
		core_ctrl.mux_sel == $past(sfr_req.wdata[2:0])
		&& pin_analog_bits[core_ctrl.mux_sel]) else $error("channel");
	chk_standby_wr: assert property (ctl_wr and !sfr_req.wdata[5]
		|-> ##[1:2] !core_ctrl.power) else $error("standby");
	chk_pin_route: assert property (sfr_req.wr
		&& sfr_req.addr == ADC_PIN_CONFIG_OFS
		|=> pin_analog_bits == $past(sfr_req.wdata)) else $error("pins");
	chk_irq_gate: assert property (!adc_irq_enable |=> !adc_irq)
		else $error("irq gate");
	chk_halt_start: assert property ($rose(cpu_halt) |-> core_ctrl.sample)
		else $error("halt start");
	chk_halt_exit: assert property ($fell(cpu_halt) |-> $past(adc_irq))
		else $error("halt exit");
	chk_hold_conv: assert property (cpu_halt && core_ctrl.sample
		|-> other_irq_hold) else $error("hold");
endmodule : adc_seq_chk

bind adc_sequencer_control adc_seq_chk u_chk (.clk(clk), .resetn(resetn),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
	.adc_irq_enable(adc_irq_enable), .cmp_above(cmp_above),
	.core_ctrl(core_ctrl), .pin_analog_bits(pin_analog_bits),
	.adc_irq(adc_irq), .cpu_halt(cpu_halt),
	.other_irq_hold(other_irq_hold));

// [sim/analog_core_model.sv]
`timescale 1ns/1ps
// Comparator stand-in for the analog core.
// Assumes the input level is given as an ideal code.
module analog_core_model
	import adc_seq_pkg::*;
(
	input core_ctrl_t core_ctrl,
	input wire logic [9:0] level,
	output logic cmp_above
);
	// Standby core gives no compare
	assign cmp_above = core_ctrl.power && level >= core_ctrl.dac_code;
endmodule : analog_core_model

// [sim/test_adc_sequencer_control.sv]
`timescale 1ns/1ps
// Self-checking bench of the converter sequencer.
// Assumes the comparator model on the analog side.
module test_adc_sequencer_control
	import adc_seq_pkg::*;
;
	logic clk, resetn, adc_irq_enable, cmp_above, adc_irq, cpu_halt;
	logic other_irq_hold, p1, p2;
	sfr_req_t sfr_req;
	core_ctrl_t core_ctrl;
	logic [7:0] sfr_rdata, pin_analog_bits, t;
	logic [9:0] level;
	logic [7:0] q[$];
	int mismatches, checked, i;
	adc_sequencer_control dut (.clk(clk), .resetn(resetn),
		.sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
		.adc_irq_enable(adc_irq_enable), .cmp_above(cmp_above),
		.core_ctrl(core_ctrl), .pin_analog_bits(pin_analog_bits),
		.adc_irq(adc_irq), .cpu_halt(cpu_halt),
		.other_irq_hold(other_irq_hold));
	analog_core_model model (.core_ctrl(core_ctrl), .level(level),
		.cmp_above(cmp_above));
	always #2.5 clk = ~clk;
	task chk(input logic [31:0] s, e);
		checked++;
		if (s !== e)
		begin
			mismatches++;
			$display("unexpected %0t got %0h want %0h", $time, s, e);
		end
	endtask : chk
	task bus(input logic [7:0] a, input logic w, r, input logic [7:0] d);
		@(posedge clk) #1 sfr_req = '{a, w, r, d};
		@(posedge clk) #1 sfr_req = '{a, 1'b0, 1'b0, d};
	endtask : bus
	task rd(input logic [7:0] a, e);
		bus(a, 1'b0, 1'b1, 8'h00);
		q.push_back(e);
	endtask : rd
	task conv(input logic [7:0] c, input logic [9:0] lv, input int d);
		int n;
		level = lv;
		n = 1;
		bus(ADC_CONTROL_OFS, 1'b1, 1'b0, c | 8'h28);
		@(posedge clk) #1;
		chk(cpu_halt, c[6]);
		chk(other_irq_hold, c[6]);
		while (adc_irq !== 1'b1 && n < 900)
		begin
			@(posedge clk) #1;
			n++;
		end
		// Polling starts one edge after the start write lands
		chk(n, 11 * d + 1);
		rd(ADC_RESULT_HIGH_OFS, lv[9:2]);
		rd(ADC_RESULT_LOW_OFS, {6'h00, lv[1:0]});
		rd(ADC_CONTROL_OFS, c | 8'h30);
		chk(cpu_halt, 1'b0);
		bus(ADC_CONTROL_OFS, 1'b1, 1'b0, c | 8'h20);
		repeat (3) @(posedge clk) #1;
		chk(adc_irq, 1'b0);
	endtask : conv
	task final_report;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	always @(posedge clk)
	begin
		p1 <= sfr_req.rd;
		p2 <= p1;
	end
	always @(negedge clk)
		if (p2 === 1'b1)
			chk(sfr_rdata, q.pop_front());
	initial
	begin
		#100000;
		mismatches++;
		final_report;
	end
	initial
	begin
		clk = 0;
		resetn = 0;
		sfr_req = '0;
		adc_irq_enable = 1;
		level = 0;
		mismatches = 0;
		checked = 0;
		i = $urandom(32'h075F);
		repeat (8) @(posedge clk);
		#1 resetn = 1;
		repeat (3) @(posedge clk);
		// F7 is unmapped and reads zero
		for (i = 2; i < 8; i++)
			rd(8'hF0 + 8'(i), 8'h00);
		bus(ADC_PIN_CONFIG_OFS, 1'b1, 1'b0, 8'hA5);
		rd(ADC_PIN_CONFIG_OFS, 8'hA5);
		chk(pin_analog_bits, 8'hA5);
		bus(ADC_CLOCK_DIVIDER_OFS, 1'b1, 1'b0, 8'h01);
		bus(ADC_CONTROL_OFS, 1'b1, 1'b0, 8'h29);
		rd(ADC_CONTROL_OFS, 8'h21);
		bus(ADC_CONTROL_OFS, 1'b1, 1'b0, 8'h08);
		rd(ADC_CONTROL_OFS, 8'h00);
		chk(core_ctrl.power, 1'b0);
		// Power up ahead of the first start; core needs no real warmup
		bus(ADC_CONTROL_OFS, 1'b1, 1'b0, 8'h20);
		repeat (4) @(posedge clk) #1;
		chk(core_ctrl.power, 1'b1);
		conv(8'h00, 10'h3FF, 2);
		conv(8'h47, 10'h000, 2);
		bus(ADC_PIN_CONFIG_OFS, 1'b1, 1'b0, 8'hFF);
		for (i = 0; i < 8; i++)
			conv({1'b0, i[0], 3'b000, i[2:0]}, 10'($urandom), 2);
		bus(ADC_CLOCK_DIVIDER_OFS, 1'b1, 1'b0, 8'h00);
		conv(8'h02, 10'($urandom), 64);
		t = 8'(1 + $urandom % 31);
		bus(ADC_CLOCK_DIVIDER_OFS, 1'b1, 1'b0, t);
		conv(8'h03, 10'($urandom), 2 * t);
		bus(ADC_CLOCK_DIVIDER_OFS, 1'b1, 1'b0, 8'h01);
		adc_irq_enable = 0;
		bus(ADC_CONTROL_OFS, 1'b1, 1'b0, 8'h2C);
		repeat (40) @(posedge clk) #1;
		chk(adc_irq, 1'b0);
		adc_irq_enable = 1;
		repeat (2) @(posedge clk) #1;
		chk(adc_irq, 1'b1);
		final_report;
	end
endmodule : test_adc_sequencer_control
